/* File: hw/exec_unit.sv */
`include "exec_regs.svh"

// Notes on behaviour
// RULE_01: byte set writes all ones to the memory byte, flags untouched.
// RULE_02: bit set forces only the chosen bit to one, flags untouched.
// RULE_03: increment memory, write back, skip next when the result is zero.
// RULE_04: memory plus one goes to accumulator, memory kept, skip on zero.
// RULE_05: skip next instruction when the chosen memory bit is one.
// RULE_06: accumulator minus memory as acc plus inverted byte plus one, into acc.
// RULE_07: same subtraction, result stored into the memory byte.
// RULE_08: accumulator minus immediate as acc plus inverted immediate plus one.
// RULE_09: nibble exchange of the memory byte in place, flags untouched.
// RULE_10: nibble-exchanged byte goes to accumulator, memory kept.
// RULE_11: a taken skip drops the prefetched instruction and adds one dummy cycle.
// RULE_12: copy memory byte to accumulator, skip next when it is zero.
// RULE_13: skip next instruction when the chosen memory bit is zero.
// RULE_14: current-page table read: low byte to memory, high byte to table high.
// RULE_15: last-page table read: low byte to memory, high byte to table high.
// RULE_16: xor into memory byte, only the zero flag changes.
// RULE_17: xor with memory or immediate into accumulator, only zero flag changes.
// RULE_18: zero flag set when the xor result is zero, other flags held.
module exec_unit (
  // clock and reset
  input  wire logic           clock,
  input  wire logic           rst,
  // instruction issue
  input  wire logic           op_valid,
  input  exec_pkg::op_e       op_code,
  input  exec_pkg::byte_t     op_addr,
  input  wire logic [2:0]     op_bit,
  input  exec_pkg::byte_t     op_imm,
  input  exec_pkg::byte_t     mem_rd_data,
  output logic                op_ready,
  output logic                discard_prefetch,
  // table read context
  input  exec_pkg::page_t     pc_page,
  input  exec_pkg::byte_t     table_pointer,
  // program memory
  output exec_pkg::rom_addr_t rom_addr,
  output logic                rom_rd_en,
  input  exec_pkg::word_t     rom_rd_data,
  // data memory write
  output logic                mem_wr_en,
  output exec_pkg::byte_t     mem_wr_addr,
  output exec_pkg::byte_t     mem_wr_data,
  // architectural state
  output exec_pkg::byte_t     acc,
  output exec_pkg::byte_t     table_high_byte,
  output logic                zero_flag,
  output logic                carry_flag,
  output logic                aux_carry_flag,
  output logic                overflow_flag
);
  import exec_pkg::*;

  typedef enum logic [1:0] {
    ST_READY,
    ST_DUMMY,
    ST_TABLE
  } state_e;

  state_e    state_reg;
  state_e    state_next;
  logic      op_ready_reg;
  logic      op_ready_next;
  logic      discard_reg;
  logic      discard_next;
  rom_addr_t rom_addr_reg;
  rom_addr_t rom_addr_next;
  logic      rom_rd_en_reg;
  logic      rom_rd_en_next;
  byte_t     tbl_dest_reg;
  byte_t     tbl_dest_next;
  logic      mem_wr_en_reg;
  logic      mem_wr_en_next;
  byte_t     mem_wr_addr_reg;
  byte_t     mem_wr_addr_next;
  byte_t     mem_wr_data_reg;
  byte_t     mem_wr_data_next;
  byte_t     acc_reg;
  byte_t     acc_next;
  byte_t     tbl_high_reg;
  byte_t     tbl_high_next;
  logic      zero_reg;
  logic      zero_next;
  logic      carry_reg;
  logic      carry_next;
  logic      aux_carry_reg;
  logic      aux_carry_next;
  logic      overflow_reg;
  logic      overflow_next;

  byte_t     alu_result;
  logic      alu_write_mem;
  logic      alu_write_acc;
  logic      alu_skip;
  logic      alu_arith;
  logic      alu_zero_only;
  logic      alu_zero;
  logic      alu_carry;
  logic      alu_aux_carry;
  logic      alu_overflow;
  logic      take;
  logic      is_table;
  page_t     table_page;

  exec_alu u_alu (
    .op_code       (op_code),
    .op_bit        (op_bit),
    .acc_in        (acc_reg),
    .mem_in        (mem_rd_data),
    .imm_in        (op_imm),
    .result        (alu_result),
    .write_mem     (alu_write_mem),
    .write_acc     (alu_write_acc),
    .skip          (alu_skip),
    .arith_flags   (alu_arith),
    .zero_only     (alu_zero_only),
    .zero_out      (alu_zero),
    .carry_out     (alu_carry),
    .aux_carry_out (alu_aux_carry),
    .overflow_out  (alu_overflow)
  );

  // issue decode shared by the state groups below
  always_comb begin
    take     = op_valid && op_ready_reg;
    is_table = (op_code == OP_TABLE_READ_CURRENT_PAGE) ||
               (op_code == OP_TABLE_READ_LAST_PAGE);
    // the page is picked at issue, so a later page change cannot bend the read
    table_page = (op_code == OP_TABLE_READ_LAST_PAGE) ? `LAST_PAGE : pc_page;
  end

  // sequencing: ready, skip and program-memory read
  always_comb begin
    state_next     = state_reg;
    discard_next   = 1'b0;
    rom_addr_next  = rom_addr_reg;
    rom_rd_en_next = 1'b0;
    tbl_dest_next  = tbl_dest_reg;
    unique case (state_reg)
      ST_READY: begin
        if (take && is_table) begin
          rom_addr_next  = {table_page, table_pointer}; // see RULE_14 see RULE_15
          rom_rd_en_next = 1'b1;
          tbl_dest_next  = op_addr;
          state_next     = ST_TABLE;
        end else if (take && alu_skip) begin
          discard_next = 1'b1; // see RULE_11
          state_next   = ST_DUMMY;
        end
      end
      ST_DUMMY: begin
        // the dummy cycle stands in for the discarded instruction
        state_next = ST_READY; // see RULE_11
      end
      ST_TABLE: begin
        state_next = ST_READY;
      end
      default: begin
        // an unused state code falls back to accepting instructions
        state_next = ST_READY;
      end
    endcase
    // ready comes from the next state, so it already drops in the dummy cycle
    op_ready_next = (state_next == ST_READY);
  end

  always_ff @(posedge clock) begin
    if (rst) begin
      state_reg     <= ST_READY;
      op_ready_reg  <= 1'b1;
      discard_reg   <= 1'b0;
      rom_addr_reg  <= '0;
      rom_rd_en_reg <= 1'b0;
      tbl_dest_reg  <= '0;
    end else begin
      state_reg     <= state_next;
      op_ready_reg  <= op_ready_next;
      discard_reg   <= discard_next;
      rom_addr_reg  <= rom_addr_next;
      rom_rd_en_reg <= rom_rd_en_next;
      tbl_dest_reg  <= tbl_dest_next;
    end
  end

  // data memory write port: alu results, or the low byte of a table word
  always_comb begin
    mem_wr_en_next   = 1'b0;
    mem_wr_addr_next = mem_wr_addr_reg;
    mem_wr_data_next = mem_wr_data_reg;
    unique case (state_reg)
      ST_READY: begin
        if (take && !is_table && alu_write_mem) begin
          mem_wr_en_next   = 1'b1;
          mem_wr_addr_next = op_addr;
          mem_wr_data_next = alu_result;
        end
      end
      ST_TABLE: begin
        // the word is taken while rom_rd_en still marks its address
        mem_wr_en_next   = 1'b1;
        mem_wr_addr_next = tbl_dest_reg;
        mem_wr_data_next = rom_rd_data[`WORD_LOW_MSB:0]; // see RULE_14 see RULE_15
      end
      default: begin
      end
    endcase
  end

  always_ff @(posedge clock) begin
    if (rst) begin
      mem_wr_en_reg   <= 1'b0;
      mem_wr_addr_reg <= '0;
      mem_wr_data_reg <= '0;
    end else begin
      mem_wr_en_reg   <= mem_wr_en_next;
      mem_wr_addr_reg <= mem_wr_addr_next;
      mem_wr_data_reg <= mem_wr_data_next;
    end
  end

  // accumulator and table high byte
  always_comb begin
    acc_next      = acc_reg;
    tbl_high_next = tbl_high_reg;
    unique case (state_reg)
      ST_READY: begin
        if (take && !is_table && alu_write_acc) begin
          acc_next = alu_result;
        end
      end
      ST_TABLE: begin
        tbl_high_next = rom_rd_data[`WORD_HIGH_MSB:`WORD_HIGH_LSB]; // see RULE_14 see RULE_15
      end
      default: begin
      end
    endcase
  end

  always_ff @(posedge clock) begin
    if (rst) begin
      acc_reg      <= `ACC_RESET;
      tbl_high_reg <= `TBL_HIGH_RESET;
    end else begin
      acc_reg      <= acc_next;
      tbl_high_reg <= tbl_high_next;
    end
  end

  // status flags: subtracts set all four, xor sets only zero, the rest hold
  always_comb begin
    zero_next      = zero_reg;
    carry_next     = carry_reg;
    aux_carry_next = aux_carry_reg;
    overflow_next  = overflow_reg;
    unique case (state_reg)
      ST_READY: begin
        if (take && !is_table) begin
          if (alu_arith) begin
            zero_next      = alu_zero;
            carry_next     = alu_carry;
            aux_carry_next = alu_aux_carry;
            overflow_next  = alu_overflow;
          end
          if (alu_zero_only) begin
            zero_next = alu_zero; // see RULE_18
          end
        end
      end
      default: begin
      end
    endcase
  end

  always_ff @(posedge clock) begin
    if (rst) begin
      zero_reg      <= `FLAG_RESET;
      carry_reg     <= `FLAG_RESET;
      aux_carry_reg <= `FLAG_RESET;
      overflow_reg  <= `FLAG_RESET;
    end else begin
      zero_reg      <= zero_next;
      carry_reg     <= carry_next;
      aux_carry_reg <= aux_carry_next;
      overflow_reg  <= overflow_next;
    end
  end

  assign op_ready         = op_ready_reg;
  assign discard_prefetch = discard_reg;
  assign rom_addr         = rom_addr_reg;
  assign rom_rd_en        = rom_rd_en_reg;
  assign mem_wr_en        = mem_wr_en_reg;
  assign mem_wr_addr      = mem_wr_addr_reg;
  assign mem_wr_data      = mem_wr_data_reg;
  assign acc              = acc_reg;
  assign table_high_byte  = tbl_high_reg;
  assign zero_flag        = zero_reg;
  assign carry_flag       = carry_reg;
  assign aux_carry_flag   = aux_carry_reg;
  assign overflow_flag    = overflow_reg;

endmodule : exec_unit

/* File: common/exec_regs.svh */
`ifndef EXEC_REGS_SVH
`define EXEC_REGS_SVH

// reset values
`define ACC_RESET       8'h00
`define TBL_HIGH_RESET  8'h00
`define FLAG_RESET      1'b0

// constants of the datapath
`define ALL_ONES        8'hFF
`define ZERO_BYTE       8'h00
`define ONE_BYTE        8'h01
`define LAST_PAGE       5'h1F

// program word fields
`define WORD_LOW_MSB    7
`define WORD_HIGH_LSB   8
`define WORD_HIGH_MSB   15

`endif

/* File: common/exec_pkg.sv */
package exec_pkg;

  typedef logic [7:0]  byte_t;
  typedef logic [15:0] word_t;
  typedef logic [4:0]  page_t;
  typedef logic [12:0] rom_addr_t;

  typedef enum logic [4:0] {
    OP_NOP,
    OP_SET_BYTE,
    OP_SET_BIT,
    OP_INCR_MEM_SKIP_ZERO,
    OP_INCR_TO_ACC_SKIP_ZERO,
    OP_SKIP_BIT_NONZERO,
    OP_SUB_TO_ACC,
    OP_SUBTRACT_TO_MEMORY,
    OP_SUB_IMM,
    OP_SWAP_MEM,
    OP_NIBBLE_EXCHANGE_TO_ACC,
    OP_SKIP_WHEN_ZERO,
    OP_MOVE_ACC_SKIP_ZERO,
    OP_SKIP_BIT_ZERO,
    OP_TABLE_READ_CURRENT_PAGE,
    OP_TABLE_READ_LAST_PAGE,
    OP_EXCLUSIVE_OR_TO_MEMORY,
    OP_XOR_TO_ACC,
    OP_XOR_IMM
  } op_e;

endpackage : exec_pkg

/* File: hw/exec_alu.sv */
`include "exec_regs.svh"

module exec_alu (
  // operation
  input  exec_pkg::op_e   op_code,
  input  wire logic [2:0] op_bit,
  // operands
  input  exec_pkg::byte_t acc_in,
  input  exec_pkg::byte_t mem_in,
  input  exec_pkg::byte_t imm_in,
  // results
  output exec_pkg::byte_t result,
  output logic            write_mem,
  output logic            write_acc,
  output logic            skip,
  output logic            arith_flags,
  output logic            zero_only,
  output logic            zero_out,
  output logic            carry_out,
  output logic            aux_carry_out,
  output logic            overflow_out
);
  import exec_pkg::*;

  byte_t      bit_mask;
  byte_t      swapped;
  byte_t      incr;
  byte_t      sub_rhs;
  logic [8:0] sum;
  logic [4:0] low_sum;

  always_comb begin
    bit_mask = byte_t'(`ONE_BYTE << op_bit);
    swapped  = {mem_in[3:0], mem_in[7:4]};
    incr     = mem_in + `ONE_BYTE;
    // subtract is add of the inverted operand with carry in set
    sub_rhs  = (op_code == OP_SUB_IMM) ? ~imm_in : ~mem_in;
    sum      = {1'b0, acc_in} + {1'b0, sub_rhs} + 9'h001;
    low_sum  = {1'b0, acc_in[3:0]} + {1'b0, sub_rhs[3:0]} + 5'h01;
    carry_out     = sum[8];
    aux_carry_out = low_sum[4];
    overflow_out  = (acc_in[7] == sub_rhs[7]) && (sum[7] != acc_in[7]);
    result      = mem_in;
    write_mem   = 1'b0;
    write_acc   = 1'b0;
    skip        = 1'b0;
    arith_flags = 1'b0;
    zero_only   = 1'b0;
    unique case (op_code)
      OP_SET_BYTE: begin
        result    = `ALL_ONES; // see RULE_01
        write_mem = 1'b1;
      end
      OP_SET_BIT: begin
        result    = mem_in | bit_mask; // see RULE_02
        write_mem = 1'b1;
      end
      OP_INCR_MEM_SKIP_ZERO: begin
        result    = incr;
        write_mem = 1'b1;
        skip      = (incr == `ZERO_BYTE); // see RULE_03
      end
      OP_INCR_TO_ACC_SKIP_ZERO: begin
        result    = incr;
        write_acc = 1'b1;
        skip      = (incr == `ZERO_BYTE); // see RULE_04
      end
      OP_SKIP_BIT_NONZERO: begin
        skip = |(mem_in & bit_mask); // see RULE_05
      end
      OP_SKIP_BIT_ZERO: begin
        skip = ~|(mem_in & bit_mask); // see RULE_13
      end
      OP_SKIP_WHEN_ZERO: begin
        skip = (mem_in == `ZERO_BYTE);
      end
      OP_MOVE_ACC_SKIP_ZERO: begin
        result    = mem_in;
        write_acc = 1'b1;
        skip      = (mem_in == `ZERO_BYTE); // see RULE_12
      end
      OP_SUB_TO_ACC: begin
        result      = sum[7:0]; // see RULE_06
        write_acc   = 1'b1;
        arith_flags = 1'b1;
      end
      OP_SUBTRACT_TO_MEMORY: begin
        result      = sum[7:0]; // see RULE_07
        write_mem   = 1'b1;
        arith_flags = 1'b1;
      end
      OP_SUB_IMM: begin
        result      = sum[7:0]; // see RULE_08
        write_acc   = 1'b1;
        arith_flags = 1'b1;
      end
      OP_SWAP_MEM: begin
        result    = swapped; // see RULE_09
        write_mem = 1'b1;
      end
      OP_NIBBLE_EXCHANGE_TO_ACC: begin
        result    = swapped; // see RULE_10
        write_acc = 1'b1;
      end
      OP_EXCLUSIVE_OR_TO_MEMORY: begin
        result    = acc_in ^ mem_in; // see RULE_16
        write_mem = 1'b1;
        zero_only = 1'b1;
      end
      OP_XOR_TO_ACC: begin
        result    = acc_in ^ mem_in; // see RULE_17
        write_acc = 1'b1;
        zero_only = 1'b1;
      end
      OP_XOR_IMM: begin
        result    = acc_in ^ imm_in; // see RULE_17
        write_acc = 1'b1;
        zero_only = 1'b1;
      end
      OP_NOP, OP_TABLE_READ_CURRENT_PAGE, OP_TABLE_READ_LAST_PAGE: begin
      end
      default: begin
      end
    endcase
    zero_out = (result == `ZERO_BYTE); // see RULE_18
  end

endmodule : exec_alu

/* File: tb/exec_unit_assertions.sv */
module exec_unit_assertions (
  // clock and reset
  input wire logic          clock,
  input wire logic          rst,
  // instruction issue
  input wire logic          op_valid,
  input exec_pkg::op_e      op_code,
  input exec_pkg::byte_t    op_addr,
  input wire logic [2:0]    op_bit,
  input exec_pkg::byte_t    op_imm,
  input exec_pkg::byte_t    mem_rd_data,
  input wire logic          op_ready,
  input wire logic          discard_prefetch,
  // table read
  input exec_pkg::byte_t    table_pointer,
  input exec_pkg::rom_addr_t rom_addr,
  input wire logic          rom_rd_en,
  input exec_pkg::word_t    rom_rd_data,
  // results
  input wire logic          mem_wr_en,
  input exec_pkg::byte_t    mem_wr_addr,
  input exec_pkg::byte_t    mem_wr_data,
  input exec_pkg::byte_t    acc,
  input exec_pkg::byte_t    table_high_byte,
  input wire logic          zero_flag,
  input wire logic          carry_flag,
  input wire logic          overflow_flag
);
  timeunit 1ns;
  timeprecision 1ps;
  import exec_pkg::*;
  logic tk;
  assign tk = op_valid && op_ready;
  default clocking @(posedge clock);
  endclocking
  default disable iff (rst);

  a_set_byte_ones: assert property (tk && op_code == OP_SET_BYTE |=> mem_wr_en
    && mem_wr_data == 8'hFF && mem_wr_addr == $past(op_addr)) else $error("byte set wrong");
  a_set_bit_only: assert property (tk && op_code == OP_SET_BIT |=> mem_wr_en
    && mem_wr_data == ($past(mem_rd_data) | (8'h01 << $past(op_bit))) && $stable(zero_flag))
    else $error("bit set wrong");
  a_incr_skip_zero: assert property (tk && op_code == OP_INCR_MEM_SKIP_ZERO |=>
    mem_wr_data == $past(mem_rd_data) + 8'h01
    && discard_prefetch == ($past(mem_rd_data) == 8'hFF)) else $error("increment skip wrong");
  a_sub_acc_value: assert property (tk && op_code == OP_SUB_TO_ACC |=> !mem_wr_en
    && acc == $past(acc) + ~$past(mem_rd_data) + 8'h01) else $error("subtract wrong");
  a_swap_to_acc: assert property (tk && op_code == OP_NIBBLE_EXCHANGE_TO_ACC |=>
    !mem_wr_en && acc == {$past(mem_rd_data[3:0]), $past(mem_rd_data[7:4])})
    else $error("swap to acc wrong");
  a_skip_dummy_cycle: assert property ($rose(discard_prefetch) |-> !op_ready
    ##1 op_ready && !discard_prefetch) else $error("skip dummy cycle wrong");
  a_table_last_page: assert property (tk && op_code == OP_TABLE_READ_LAST_PAGE |=>
    rom_rd_en && !op_ready && rom_addr == {5'h1F, $past(table_pointer)} ##1 mem_wr_en
    && table_high_byte == $past(rom_rd_data[15:8]) && mem_wr_data == $past(rom_rd_data[7:0]))
    else $error("table read wrong");
  a_xor_zero_only: assert property (tk && op_code == OP_XOR_IMM |=>
    acc == ($past(acc) ^ $past(op_imm)) && zero_flag == (acc == 8'h00)
    && $stable(carry_flag) && $stable(overflow_flag)) else $error("xor flags wrong");
endmodule : exec_unit_assertions

bind exec_unit exec_unit_assertions i_exec_unit_assertions (.clock, .rst, .op_valid, .op_code,
  .op_addr, .op_bit, .op_imm, .mem_rd_data, .op_ready, .discard_prefetch, .table_pointer,
  .rom_addr, .rom_rd_en, .rom_rd_data, .mem_wr_en, .mem_wr_addr, .mem_wr_data, .acc,
  .table_high_byte, .zero_flag, .carry_flag, .overflow_flag);

/* File: tb/exec_mem_model.sv */
module exec_mem_model (
  input wire logic           clock,
  input exec_pkg::byte_t     op_addr,
  output exec_pkg::byte_t    mem_rd_data,
  input wire logic           mem_wr_en,
  input exec_pkg::byte_t     mem_wr_addr,
  input exec_pkg::byte_t     mem_wr_data,
  input exec_pkg::rom_addr_t rom_addr,
  input wire logic           rom_rd_en,
  output exec_pkg::word_t    rom_rd_data
);
  timeunit 1ns;
  timeprecision 1ps;
  import exec_pkg::*;
  byte_t ram [256];
  word_t wd;
  assign mem_rd_data = ram[op_addr];
  assign wd = {8'hC0 ^ rom_addr[7:0], 3'h0, rom_addr[12:8]};
  // outside the read cycle the word flips so a late sample cannot pass
  assign rom_rd_data = rom_rd_en ? wd : ~wd;
  always @(posedge clock) begin
    if (mem_wr_en) begin
      ram[mem_wr_addr] <= mem_wr_data;
    end
  end
endmodule : exec_mem_model

/* File: tb/test_mcu_bit_skip_sub_swap_xor_exec.sv */
module test_mcu_bit_skip_sub_swap_xor_exec;
  timeunit 1ns;
  timeprecision 1ps;
  import exec_pkg::*;
  logic      clock, rst, op_valid, op_ready, discard_prefetch, rom_rd_en, mem_wr_en;
  logic      zero_flag, carry_flag, aux_carry_flag, overflow_flag;
  op_e       op_code;
  byte_t     op_addr, op_imm, mem_rd_data, table_pointer, mem_wr_addr, mem_wr_data;
  byte_t     acc, table_high_byte;
  logic [2:0] op_bit;
  page_t     pc_page;
  rom_addr_t rom_addr;
  word_t     rom_rd_data;
  int        error_cnt, checks_done;

  exec_unit i_exec_unit (.*);
  exec_mem_model i_exec_mem_model (.clock, .op_addr, .mem_rd_data, .mem_wr_en, .mem_wr_addr,
    .mem_wr_data, .rom_addr, .rom_rd_en, .rom_rd_data);

  initial begin
    clock = 1'b0;
    forever #4 clock = ~clock;
  end

  task automatic check(input string n, input byte_t e, input byte_t g);
    checks_done++;
    if (g !== e) begin
      error_cnt++;
      $display("mismatch %s expected %h seen %h", n, e, g);
    end
  endtask : check

  task automatic put(input byte_t a, input byte_t v);
    i_exec_mem_model.ram[a] = v;
  endtask : put

  // issue one op, then idle long enough for table reads and dummy cycles
  task automatic run(input op_e c, input byte_t a, input logic [2:0] b, input byte_t im,
                     input logic sk);
    op_code = c;
    op_addr = a;
    op_bit = b;
    op_imm = im;
    op_valid = 1'b1;
    @(posedge clock);
    #1 op_valid = 1'b0;
    check("skip", {7'h00, sk}, {7'h00, discard_prefetch});
    check("ready", {7'h00, !(sk || c == OP_TABLE_READ_CURRENT_PAGE ||
          c == OP_TABLE_READ_LAST_PAGE)}, {7'h00, op_ready});
    repeat (2) @(posedge clock);
    #1;
  endtask : run

  task automatic load_acc(input byte_t v);
    put(8'hC8, v);
    run(OP_MOVE_ACC_SKIP_ZERO, 8'hC8, 3'h0, 8'h00, v == 8'h00);
    check("acc load", v, acc);
  endtask : load_acc

  task automatic t_sub;
    load_acc(8'h30);
    put(8'h01, 8'h10);
    run(OP_SUB_TO_ACC, 8'h01, 3'h0, 8'h00, 1'b0);
    check("sub acc", 8'h20, acc);
    check("sub aux", 8'h01, {7'h00, aux_carry_flag});
    run(OP_SUB_IMM, 8'h00, 3'h0, 8'h21, 1'b0);
    check("sub imm", 8'hFF, acc);
    check("borrow", 8'h00, {7'h00, carry_flag});
    put(8'h02, 8'h0F);
    run(OP_SUBTRACT_TO_MEMORY, 8'h02, 3'h0, 8'h00, 1'b0);
    check("sub mem", 8'hF0, i_exec_mem_model.ram[2]);
    check("sub mem acc", 8'hFF, acc);
    load_acc(8'h80);
    run(OP_SUB_IMM, 8'h00, 3'h0, 8'h01, 1'b0);
    check("sub ovf", 8'h7F, acc);
    check("ovf flag", 8'h01, {7'h00, overflow_flag});
    check("ovf aux", 8'h00, {7'h00, aux_carry_flag});
  endtask : t_sub

  task automatic t_set;
    put(8'h03, 8'h12);
    run(OP_SET_BYTE, 8'h03, 3'h0, 8'h00, 1'b0);
    check("set byte", 8'hFF, i_exec_mem_model.ram[3]);
    check("set carry", 8'h01, {7'h00, carry_flag});
    put(8'h04, 8'h21);
    run(OP_SET_BIT, 8'h04, 3'h7, 8'h00, 1'b0);
    check("set bit", 8'hA1, i_exec_mem_model.ram[4]);
    check("bit carry", 8'h01, {7'h00, carry_flag});
  endtask : t_set

  task automatic t_incr_skip;
    put(8'h05, 8'hFF);
    run(OP_INCR_MEM_SKIP_ZERO, 8'h05, 3'h0, 8'h00, 1'b1);
    check("incr mem", 8'h00, i_exec_mem_model.ram[5]);
    put(8'h06, 8'h41);
    run(OP_INCR_TO_ACC_SKIP_ZERO, 8'h06, 3'h0, 8'h00, 1'b0);
    check("incr acc", 8'h42, acc);
    check("incr kept", 8'h41, i_exec_mem_model.ram[6]);
    put(8'h07, 8'h01);
    put(8'h08, 8'h00);
    run(OP_SKIP_BIT_NONZERO, 8'h07, 3'h0, 8'h00, 1'b1);
    run(OP_SKIP_BIT_NONZERO, 8'h07, 3'h7, 8'h00, 1'b0);
    run(OP_SKIP_BIT_ZERO, 8'h07, 3'h0, 8'h00, 1'b0);
    run(OP_SKIP_BIT_ZERO, 8'h07, 3'h1, 8'h00, 1'b1);
    run(OP_SKIP_WHEN_ZERO, 8'h07, 3'h0, 8'h00, 1'b0);
    run(OP_SKIP_WHEN_ZERO, 8'h08, 3'h0, 8'h00, 1'b1);
    load_acc(8'h00);
  endtask : t_incr_skip

  task automatic t_swap_table;
    put(8'h09, 8'h3C);
    run(OP_SWAP_MEM, 8'h09, 3'h0, 8'h00, 1'b0);
    check("swap mem", 8'hC3, i_exec_mem_model.ram[9]);
    run(OP_NIBBLE_EXCHANGE_TO_ACC, 8'h09, 3'h0, 8'h00, 1'b0);
    check("swap acc", 8'h3C, acc);
    check("swap kept", 8'hC3, i_exec_mem_model.ram[9]);
    pc_page = 5'h03;
    table_pointer = 8'h44;
    run(OP_TABLE_READ_CURRENT_PAGE, 8'h0A, 3'h0, 8'h00, 1'b0);
    check("tbl low", 8'h03, i_exec_mem_model.ram[10]);
    check("tbl high", 8'h84, table_high_byte);
    table_pointer = 8'h12;
    run(OP_TABLE_READ_LAST_PAGE, 8'h0B, 3'h0, 8'h00, 1'b0);
    check("last low", 8'h1F, i_exec_mem_model.ram[11]);
    check("last high", 8'hD2, table_high_byte);
  endtask : t_swap_table

  task automatic t_xor;
    load_acc(8'h5A);
    put(8'h0C, 8'h5A);
    run(OP_XOR_TO_ACC, 8'h0C, 3'h0, 8'h00, 1'b0);
    check("xor acc", 8'h00, acc);
    check("xor zero", 8'h01, {7'h00, zero_flag});
    run(OP_XOR_IMM, 8'h00, 3'h0, 8'h0F, 1'b0);
    check("xor imm", 8'h0F, acc);
    run(OP_EXCLUSIVE_OR_TO_MEMORY, 8'h0C, 3'h0, 8'h00, 1'b0);
    check("xor mem", 8'h55, i_exec_mem_model.ram[12]);
    check("xor nz", 8'h00, {7'h00, zero_flag});
    check("xor carry", 8'h01, {7'h00, carry_flag});
  endtask : t_xor

  task automatic summarize;
    if (error_cnt == 0 && checks_done > 0) begin
      $display("TEST PASSED");
    end else begin
      $display("TEST FAILED");
    end
    $finish;
  endtask : summarize

  initial begin
    #(8 * 3000);
    error_cnt++;
    summarize();
  end

  initial begin
    error_cnt = 0;
    checks_done = 0;
    rst = 1'b1;
    op_valid = 1'b0;
    op_code = OP_NOP;
    op_addr = 8'h00;
    op_bit = 3'h0;
    op_imm = 8'h00;
    pc_page = 5'h00;
    table_pointer = 8'h00;
    repeat (20) @(posedge clock);
    #1 rst = 1'b0;
    t_sub();
    t_set();
    t_incr_skip();
    t_swap_table();
    t_xor();
    summarize();
  end
endmodule : test_mcu_bit_skip_sub_swap_xor_exec
